// ---- rtl/lig_global_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: long option: loss after 4096 zeros
// R2: short option: loss after 175 zeros
// R3: float bit set: all outputs undriven (here only board_test_float is raised; this block's outputs stay driven)
// R4: float bit clear: outputs driven normally
// R5: software writes zero to ctrl2 bits
// R6: ctrl3 bits unused, no function
// R7: decode four-bit master rate code
// R8: system supplies matching master clock frequency
// R9: a one restarts the zero counter
module lig_global_ctrl
	import lig_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [7:0]  rx_sym_valid,
	input  wire logic [7:0]  rx_sym_one,
	output logic      [7:0]  receive_signal_loss,
	output logic             board_test_float,
	output logic             long_zero_run_enable,
	output logic      [3:0]  master_rate_select,
	output logic             master_rate_valid,
	output logic             irq
);
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl5_q;
	logic [7:0] rate_q;
	logic [7:0] stat_q;
	logic [7:0] mask_q;
	logic [7:0] stat_d;
	logic [7:0] rdata_d;
	logic [7:0] los_now;
	logic [7:0] los_prev_q;

	wire sel_c1   = (reg_addr == LIG_OFS_CTRL1);
	wire sel_c2   = (reg_addr == LIG_OFS_CTRL2);
	wire sel_c3   = (reg_addr == LIG_OFS_CTRL3);
	wire sel_c5   = (reg_addr == LIG_OFS_CTRL5);
	wire sel_rate = (reg_addr == LIG_OFS_RATE);
	wire sel_stat = (reg_addr == LIG_OFS_IRQ_STAT);
	wire sel_mask = (reg_addr == LIG_OFS_IRQ_MASK);
	wire sel_los  = (reg_addr == LIG_OFS_LOS_STAT);

	wire       long_run  = ctrl1_q[LIG_BIT_LONGRUN];
	wire [3:0] rate_code = rate_q[3:0];
	// reserved codes sit between 0010 and 0111 [R7]
	wire       rate_ok   = !((rate_code >= LIG_RATE_RSVD_LO) && (rate_code <= LIG_RATE_RSVD_HI));

	// codes 1110 and 1111 alias onto 2.048 and 1.544
	lig_rate_e rate_dec;
	always_comb
	begin
		case (rate_code)
			4'h0:    rate_dec = LIG_F2048;  // [R7]
			4'he:    rate_dec = LIG_F2048;
			4'h1:    rate_dec = LIG_F1544;
			4'hf:    rate_dec = LIG_F1544;
			4'h8:    rate_dec = LIG_F4096;
			4'h9:    rate_dec = LIG_F3088;
			4'ha:    rate_dec = LIG_F8192;
			4'hb:    rate_dec = LIG_F6176;
			4'hc:    rate_dec = LIG_F16384;
			4'hd:    rate_dec = LIG_F12352;
			default: rate_dec = LIG_FBAD;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < LIG_NCH; g++)
		begin : g_ch
			lig_zero_run u_run (
				.sys_clk   (sys_clk),
				.rst_n     (rst_n),
				.sym_valid (rx_sym_valid[g]),
				.sym_one   (rx_sym_one[g]),
				.long_run  (long_run),     // [R1] [R2]
				.loss_q    (los_now[g])
			);
		end
	endgenerate

	// rising loss per channel is the event; set beats a write-one clear
	wire [7:0] los_rise = los_now & ~los_prev_q;
	wire [7:0] stat_clr = (reg_wr && sel_stat) ? reg_wdata : 8'h00;
	assign stat_d = (stat_q & ~stat_clr) | los_rise;

	// irq looks at the mask as written this cycle so it never lags the status
	wire [7:0] mask_d = (reg_wr && sel_mask) ? reg_wdata : mask_q;

	// ctrl3 holds nothing and reads zero; ctrl2 stored as written [R5] [R6]
	assign rdata_d = !reg_rd  ? 8'h00 :
	                 sel_c1   ? ctrl1_q :
	                 sel_c2   ? ctrl2_q :
	                 sel_c3   ? 8'h00 :
	                 sel_c5   ? ctrl5_q :
	                 sel_rate ? rate_q :
	                 sel_stat ? stat_q :
	                 sel_mask ? mask_q :
	                 sel_los  ? los_now : 8'h00;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl1_q <= LIG_RST_CTRL1;
			ctrl2_q <= LIG_RST_CTRL2;
			ctrl5_q <= LIG_RST_CTRL5;
			rate_q  <= LIG_RST_RATE;
		end
		else if (reg_wr)
		begin
			if (sel_c1)
				ctrl1_q <= reg_wdata;
			if (sel_c2)
				ctrl2_q <= reg_wdata;
			if (sel_c5)
				ctrl5_q <= reg_wdata;
			if (sel_rate)
				rate_q <= {4'h0, reg_wdata[3:0]};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stat_q     <= 8'h00;
			mask_q     <= LIG_RST_MASK;
			los_prev_q <= 8'h00;
			reg_rdata  <= 8'h00;
		end
		else
		begin
			stat_q     <= stat_d;
			los_prev_q <= los_now;
			reg_rdata  <= rdata_d;
			if (reg_wr && sel_mask)
				mask_q <= reg_wdata;
		end
	end

	// outputs registered; float follows ctrl1 bit 0 one cycle later
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			receive_signal_loss  <= 8'h00;
			board_test_float     <= 1'b0;
			long_zero_run_enable <= 1'b0;
			master_rate_select   <= 4'h1;
			master_rate_valid    <= 1'b1;
			irq                  <= 1'b0;
		end
		else
		begin
			// in float mode only board_test_float is raised; this block's outputs stay driven [R3] [R4]
			board_test_float     <= ctrl1_q[LIG_BIT_FLOAT];
			receive_signal_loss  <= los_now;
			long_zero_run_enable <= long_run;
			master_rate_select   <= rate_dec;    // [R7]
			master_rate_valid    <= rate_ok;      // [R7]
			irq                  <= |(stat_d & mask_d);
		end
	end

	AST_FLOAT_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(ctrl1_q[LIG_BIT_FLOAT]) |=> board_test_float) // [R3]
		else $error("float not entered");
	AST_FLOAT_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(ctrl1_q[LIG_BIT_FLOAT]) |=> !board_test_float) // [R4]
		else $error("float not released");
	AST_SHORT_RUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!long_run && !los_now[0] ##1 los_now[0] |-> $past(rx_sym_valid[0])) // [R2]
		else $error("loss rose without a symbol");
	AST_LONG_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		long_run && $past(long_run) && !los_now[0] && !rx_sym_valid[0]
		|=> !los_now[0]) // [R1]
		else $error("loss rose with no symbol");
	AST_RATE_ALIAS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rate_code == 4'he |=> master_rate_select == 4'h0) // [R7]
		else $error("1110 not mapped to 2.048");
	AST_RATE_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rate_code == 4'h3 |=> !master_rate_valid) // [R7]
		else $error("reserved rate flagged valid");
	AST_CTRL3_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_c3 |=> reg_rdata == 8'h00) // [R6]
		else $error("ctrl3 read nonzero");
	AST_IRQ_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(los_rise & mask_d) != 8'h00 |=> irq ##1 stat_q != 8'h00)
		else $error("masked loss event missed");
	COV_FLOAT: cover property (@(posedge sys_clk) $rose(board_test_float));
	COV_LOSS: cover property (@(posedge sys_clk) $rose(receive_signal_loss[0]));
	COV_IRQ: cover property (@(posedge sys_clk) $rose(irq));
	COV_LONG: cover property (@(posedge sys_clk) long_run && $rose(los_now[0]));
	COV_RSVD: cover property (@(posedge sys_clk) $fell(master_rate_valid));

	// read path: every mapped register returns what it held at the strobe
	AST_RD_C1: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_c1
		|=> reg_rdata == $past(ctrl1_q))
		else $error("ctrl1 read wrong");

	AST_RD_C2: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_c2
		|=> reg_rdata == $past(ctrl2_q)) // [R5]
		else $error("ctrl2 read wrong");

	AST_RD_C5: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_c5
		|=> reg_rdata == $past(ctrl5_q))
		else $error("ctrl5 read wrong");

	AST_RD_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_rate
		|=> reg_rdata == $past(rate_q)) // [R7]
		else $error("rate read wrong");

	AST_RD_STAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_stat
		|=> reg_rdata == $past(stat_q))
		else $error("status read wrong");

	AST_RD_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_mask
		|=> reg_rdata == $past(mask_q))
		else $error("mask read wrong");

	AST_RD_LOS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && sel_los
		|=> reg_rdata == $past(los_now))
		else $error("live loss read wrong");

	// read data stands only in each cycle after a read strobe, zero otherwise
	AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!reg_rd
		|=> reg_rdata == 8'h00)
		else $error("read data without a read");

	// write path
	AST_WR_C1: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && sel_c1
		|=> ctrl1_q == $past(reg_wdata)) // [R3]
		else $error("ctrl1 write lost");

	AST_WR_C2: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && sel_c2
		|=> ctrl2_q == $past(reg_wdata)) // [R5]
		else $error("ctrl2 write lost");

	AST_WR_C5: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && sel_c5
		|=> ctrl5_q == $past(reg_wdata))
		else $error("ctrl5 write lost");

	AST_WR_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && sel_mask
		|=> mask_q == $past(reg_wdata))
		else $error("mask write lost");

	AST_WR_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && sel_rate
		|=> rate_q[3:0] == $past(reg_wdata[3:0])) // [R7]
		else $error("rate write lost");

	// the upper nibble of the rate register never holds anything
	AST_RATE_HI: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|-> rate_q[7:4] == 4'h0) // [R7]
		else $error("rate upper nibble set");

	// outputs except irq are one-cycle registered copies of the internal state; irq is registered from the next status and mask
	AST_FLOAT_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|=> board_test_float == $past(ctrl1_q[LIG_BIT_FLOAT])) // [R3] [R4]
		else $error("float output out of step");

	AST_LONG_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|=> long_zero_run_enable == $past(long_run)) // [R1]
		else $error("long option output out of step");

	AST_LOSS_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|=> receive_signal_loss == $past(los_now)) // [R1] [R2]
		else $error("loss output out of step");

	AST_RATE_SEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|=> master_rate_select == $past(rate_dec)) // [R7]
		else $error("rate select out of step");

	AST_RATE_F1544: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rate_code == 4'hf
		|=> master_rate_select == 4'h1) // [R7]
		else $error("1111 not mapped to 1.544");

	AST_RATE_BAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|-> (rate_dec == LIG_FBAD) == !rate_ok) // [R7]
		else $error("reserved decode and flag disagree");

	// sticky status: set wins, write-one clears, otherwise held
	AST_STAT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		los_rise != 8'h00
		|=> (stat_q & $past(los_rise)) == $past(los_rise))
		else $error("loss event not latched");

	AST_STAT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && sel_stat && los_rise == 8'h00
		|=> (stat_q & $past(reg_wdata)) == 8'h00)
		else $error("status not cleared");

	AST_STAT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		los_rise == 8'h00 && !(reg_wr && sel_stat)
		|=> $stable(stat_q))
		else $error("status changed without cause");

	AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1
		|-> irq == |(stat_q & mask_q))
		else $error("irq disagrees with status and mask");
endmodule
`default_nettype wire

// ---- rtl/lig_pkg.sv ----
package lig_pkg;
	// register offsets
	localparam logic [11:0] LIG_OFS_CTRL1     = 12'hfe1;
	localparam logic [11:0] LIG_OFS_CTRL2     = 12'hfe2;
	localparam logic [11:0] LIG_OFS_CTRL3     = 12'hfe4;
	localparam logic [11:0] LIG_OFS_CTRL5     = 12'hfea;
	localparam logic [11:0] LIG_OFS_RATE      = 12'hfe8;
	localparam logic [11:0] LIG_OFS_IRQ_STAT  = 12'hfec;
	localparam logic [11:0] LIG_OFS_IRQ_MASK  = 12'hfed;
	localparam logic [11:0] LIG_OFS_LOS_STAT  = 12'hfee;
	// field positions
	localparam int LIG_BIT_FLOAT    = 0;
	localparam int LIG_BIT_LONGRUN  = 1;
	// reset values
	localparam logic [7:0] LIG_RST_CTRL1 = 8'h00;
	localparam logic [7:0] LIG_RST_CTRL2 = 8'h00;
	localparam logic [7:0] LIG_RST_CTRL5 = 8'h00;
	localparam logic [7:0] LIG_RST_RATE  = 8'h01;
	localparam logic [7:0] LIG_RST_MASK  = 8'h00;
	// zero-run thresholds
	localparam logic [12:0] LIG_ZRUN_SHORT = 13'd175;
	localparam logic [12:0] LIG_ZRUN_LONG  = 13'd4096;
	localparam int          LIG_NCH        = 8;
	// rate codes
	localparam logic [3:0] LIG_RATE_RSVD_LO = 4'h2;
	localparam logic [3:0] LIG_RATE_RSVD_HI = 4'h7;
	typedef enum logic [3:0] {
		LIG_F2048  = 4'b0000,
		LIG_F1544  = 4'b0001,
		LIG_F4096  = 4'b1000,
		LIG_F3088  = 4'b1001,
		LIG_F8192  = 4'b1010,
		LIG_F6176  = 4'b1011,
		LIG_F16384 = 4'b1100,
		LIG_F12352 = 4'b1101,
		LIG_FBAD   = 4'b0111
	} lig_rate_e;
endpackage

// ---- rtl/lig_zero_run.sv ----
`timescale 1ns/1ps
`default_nettype none
module lig_zero_run
	import lig_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        sym_valid,
	input  wire logic        sym_one,
	input  wire logic        long_run,
	output logic             loss_q
);
	logic [12:0] cnt_q;
	logic [12:0] cnt_d;
	logic        loss_d;
	wire  [12:0] limit = long_run ? LIG_ZRUN_LONG : LIG_ZRUN_SHORT;
	wire         at_lim = (cnt_q >= limit);

	// counter saturates at the threshold so a long idle line never wraps
	assign cnt_d  = (sym_valid && sym_one) ? 13'h0000 :           // [R9]
	                (sym_valid && !at_lim) ? cnt_q + 13'h0001 : cnt_q;
	assign loss_d = (cnt_d >= limit);                              // [R1] [R2]

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= 13'h0000;
			loss_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			loss_q <= loss_d;
		end
	end

	AST_ONE_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sym_valid && sym_one |=> cnt_q == 13'h0000 ##0 !loss_q) // [R9]
		else $error("zero run did not restart on a one");
endmodule
`default_nettype wire

// ---- dv/line_iface_global_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_iface_global_control_test
	import lig_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  rx_sym_valid = 8'h00;
	logic [7:0]  rx_sym_one = 8'h00;
	logic [7:0]  reg_rdata, receive_signal_loss, loss_m, rnd;
	logic        board_test_float, long_zero_run_enable, master_rate_valid, irq;
	logic [3:0]  master_rate_select, rexp;
	logic [11:0] ra [9] = '{12'hfe1, 12'hfe2, 12'hfe4, 12'hfea, 12'hfe8, 12'hfed, 12'hfec,
		12'hfee, 12'hf00};
	logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	int          fail_count = 0;
	int          samples_checked = 0;
	int          thr = 175;
	int          zc [8] = '{default: 0};

	initial forever #2 sys_clk = ~sys_clk;

	lig_global_ctrl dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rx_sym_valid, .rx_sym_one, .receive_signal_loss, .board_test_float,
		.long_zero_run_enable, .master_rate_select, .master_rate_valid, .irq);

	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// write effects reach the outputs one edge after the write edge, irq at the write edge itself
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic rd(string nm, logic [11:0] a, logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, e);
	endtask

	// channel 0 gets the chosen symbol, the others random ones
	task automatic syms(int n, logic b0);
		logic [7:0] v;
		repeat (n)
		begin
			@(posedge sys_clk);
			v = {7'($urandom), b0};
			rx_sym_one <= v;
			rx_sym_valid <= 8'hff;
			for (int i = 0; i < 8; i++)
				zc[i] = v[i] ? 0 : zc[i] + 1;
		end
		@(posedge sys_clk);
		rx_sym_valid <= 8'h00;
		repeat (2) @(posedge sys_clk);
		#1;
		for (int i = 0; i < 8; i++)
			loss_m[i] = zc[i] >= thr;
	endtask

	initial
	begin
		void'($urandom(32'h204d3e1f));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1 chk("rate_sel", master_rate_select, 4'h1);
		for (int i = 0; i < 9; i++)
			rd("reset_val", ra[i], rv[i]);
		wr(LIG_OFS_CTRL3, 8'hff);
		rd("ctrl3", LIG_OFS_CTRL3, 8'h00);
		wr(LIG_OFS_CTRL2, 8'h00);
		rd("ctrl2", LIG_OFS_CTRL2, 8'h00);
		rnd = 8'($urandom);
		wr(LIG_OFS_CTRL5, rnd);
		rd("ctrl5", LIG_OFS_CTRL5, rnd);
		wr(LIG_OFS_CTRL1, 8'h01);
		chk("float", board_test_float, 1'b1);
		wr(LIG_OFS_CTRL1, 8'h00);
		chk("float", board_test_float, 1'b0);
		for (int c = 0; c < 16; c++)
		begin
			rexp = (c == 14) ? 4'h0 : (c == 15) ? 4'h1 : (c >= 2 && c <= 7) ? 4'h7 : 4'(c);
			wr(LIG_OFS_RATE, 8'(c));
			chk("rate_sel", master_rate_select, rexp);
			chk("rate_ok", master_rate_valid, !(c >= 2 && c <= 7));
			rd("rate", LIG_OFS_RATE, 8'(c));
		end
		wr(LIG_OFS_RATE, 8'h01);
		wr(LIG_OFS_IRQ_MASK, 8'h01);
		syms(174, 1'b0);
		syms(1, 1'b1);
		syms(174, 1'b0);
		chk("loss", receive_signal_loss, loss_m);
		chk("irq", irq, 1'b0);
		syms(1, 1'b0);
		chk("loss", receive_signal_loss, loss_m);
		chk("irq", irq, 1'b1);
		rd("irq_stat", LIG_OFS_IRQ_STAT, 8'h01);
		rd("los_stat", LIG_OFS_LOS_STAT, loss_m);
		wr(LIG_OFS_IRQ_STAT, 8'h01);
		chk("irq", irq, 1'b0);
		wr(LIG_OFS_CTRL1, 8'h02);
		chk("long_en", long_zero_run_enable, 1'b1);
		thr = 4096;
		syms(1, 1'b1);
		syms(4095, 1'b0);
		chk("loss", receive_signal_loss, loss_m);
		syms(1, 1'b0);
		chk("loss", receive_signal_loss, loss_m);
		chk("irq", irq, 1'b1);
		stop_test();
	end

	initial
	begin
		repeat (100000) @(posedge sys_clk);
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
